// File: edc_event_filter.v
// Event filter chain: inversion, debounce, chatter lock-out, record log.
// Assumes raw inputs asynchronous to core_clk and a reader that takes
// at most one record per application cycle.
//
// Overview of operation
// - Change starts debounce timer, holds forwarding
// - Return before expiry cancels, no event
// - Expiry with new level forwards it
// - Forwarded event keeps first-detection time stamp
// - Debounce 0..32767 ms; zero bypasses
// - Debounce time zero after reset
// - Optional per-input inversion before filtering
// - Filtering covers first 200 inputs
// - Invert, debounce, chatter, then log; per-input
// - Blocking chatter filter discards all transitions
// - Non-blocking filter passes without added delay
// - Event on entering and leaving block
// - Short stable period counts; long clears counter
// - Chatter time in 100 ms; zero disables
// - Count over limit enters block state
// - Change limit configurable 1 to 255
// - Block lasts block time, then passes
// - Record: value, 64-bit stamp, blocked, overflow
// - Time stamps in one millisecond steps
// - Capture runs regardless of reader timing
// - Reader takes each record once, then removed
`timescale 1ns/1ps
`default_nettype none
`include "edc_regs.vh"

module edc_event_filter #(
  parameter MS_CYCLES = `EDC_MS_CYCLES
) (
  input wire core_clk, // System clock, 100 MHz
  input wire reset, // Synchronous reset, active high
  input wire [`EDC_NUM_INPUTS-1:0] binary_input_value, // Raw input pins
  input wire cfg_write, // Store configuration for cfg_index
  input wire [`EDC_IDX_W-1:0] cfg_index, // Input being configured
  input wire cfg_invert, // Invert this input
  input wire [`EDC_DB_W-1:0] cfg_debounce_ms, // Debounce time, ms
  input wire [`EDC_CT_W-1:0] cfg_chatter_time, // Chatter time, 100 ms
  input wire [`EDC_LIM_W-1:0] cfg_chatter_limit, // Allowed changes
  input wire [`EDC_CT_W-1:0] cfg_block_time, // Block time, 100 ms
  output wire rec_valid, // Record available
  input wire rec_ready, // Reader takes record
  output wire [`EDC_IDX_W-1:0] rec_index, // Input number
  output wire rec_value, // Filtered input level
  output wire [`EDC_TS_W-1:0] rec_time, // Time stamp, ms
  output wire rec_blocked, // Chatter block active
  output wire rec_overflow, // Records lost before this one
  output wire [`EDC_TS_W-1:0] now_ms, // Running ms time base
  output wire overflow_pending // A drop awaits reporting
);

  localparam integer LAST_I = `EDC_NUM_INPUTS - 1;
  localparam integer TICK_LAST_I = MS_CYCLES - 1;
  localparam [`EDC_IDX_W-1:0] LAST_IDX = LAST_I[`EDC_IDX_W-1:0];
  localparam [`EDC_TICK_W-1:0] TICK_LAST = TICK_LAST_I[`EDC_TICK_W-1:0];

  function [`EDC_TS_W-1:0] age;
    input [`EDC_TS_W-1:0] later;
    input [`EDC_TS_W-1:0] since;
    begin
      age = later - since;
    end
  endfunction

  function [`EDC_CHMS_W-1:0] chat_ms;
    input [`EDC_CT_W-1:0] units;
    begin
      chat_ms = {7'h00, units} * `EDC_CHAT_UNIT_MS;
    end
  endfunction

  reg [`EDC_NUM_INPUTS-1:0] in_meta;
  reg [`EDC_NUM_INPUTS-1:0] in_sync;
  reg [`EDC_TICK_W-1:0] tick_cnt;
  reg [`EDC_TS_W-1:0] time_ms;
  reg [`EDC_IDX_W-1:0] idx;
  reg ovf_flag;

  reg cfg_inv [0:`EDC_NUM_INPUTS-1];
  reg [`EDC_DB_W-1:0] cfg_db [0:`EDC_NUM_INPUTS-1];
  reg [`EDC_CT_W-1:0] cfg_ct [0:`EDC_NUM_INPUTS-1];
  reg [`EDC_LIM_W-1:0] cfg_lim [0:`EDC_NUM_INPUTS-1];
  reg [`EDC_CT_W-1:0] cfg_bt [0:`EDC_NUM_INPUTS-1];

  reg db_level [0:`EDC_NUM_INPUTS-1];
  reg db_pend [0:`EDC_NUM_INPUTS-1];
  reg [`EDC_TS_W-1:0] db_ts [0:`EDC_NUM_INPUTS-1];
  reg ch_level [0:`EDC_NUM_INPUTS-1];
  reg ch_blk [0:`EDC_NUM_INPUTS-1];
  reg [`EDC_LIM_W-1:0] ch_cnt [0:`EDC_NUM_INPUTS-1];
  reg [`EDC_TS_W-1:0] ch_last [0:`EDC_NUM_INPUTS-1];
  reg [`EDC_TS_W-1:0] ch_blk_ts [0:`EDC_NUM_INPUTS-1];

  reg raw;
  reg fwd;
  reg [`EDC_TS_W-1:0] fwd_ts;
  reg next_db_level;
  reg next_db_pend;
  reg [`EDC_TS_W-1:0] next_db_ts;
  reg next_ch_level;
  reg next_ch_blk;
  reg [`EDC_LIM_W-1:0] next_ch_cnt;
  reg [`EDC_TS_W-1:0] next_ch_last;
  reg [`EDC_TS_W-1:0] next_ch_blk_ts;
  reg emit;
  reg emit_val;
  reg emit_blk;
  reg [`EDC_TS_W-1:0] emit_ts;
  reg short_gap;

  wire buf_ready;
  wire wr_ok;
  wire drop;
  wire [`EDC_REC_W-1:0] rec_in;
  wire [`EDC_REC_W-1:0] rec_out;
  wire ms_tick;
  integer i;

  assign ms_tick = (tick_cnt == TICK_LAST);
  assign now_ms = time_ms;
  assign overflow_pending = ovf_flag;

  // Inputs cross into core_clk before any filtering
  always @(posedge core_clk) begin
    if (reset) begin
      in_meta <= {`EDC_NUM_INPUTS{1'b0}};
      in_sync <= {`EDC_NUM_INPUTS{1'b0}};
    end else begin
      in_meta <= binary_input_value;
      in_sync <= in_meta;
    end
  end

  // Millisecond time base and running 64-bit stamp
  always @(posedge core_clk) begin
    if (reset) begin
      tick_cnt <= {`EDC_TICK_W{1'b0}};
      time_ms <= {`EDC_TS_W{1'b0}};
    end else if (ms_tick) begin
      tick_cnt <= {`EDC_TICK_W{1'b0}};
      time_ms <= time_ms + 64'h1;
    end else begin
      tick_cnt <= tick_cnt + 17'h00001;
    end
  end

  // One input is visited per cycle; a full sweep takes 2 us, far below
  // the 1 ms stamp step, so detection adds no visible stamp error.
  always @* begin
    raw = in_sync[idx] ^ cfg_inv[idx];
    fwd = 1'b0;
    fwd_ts = time_ms;
    next_db_level = db_level[idx];
    next_db_pend = db_pend[idx];
    next_db_ts = db_ts[idx];
    if (cfg_db[idx] == `EDC_RST_DB) begin
      next_db_pend = 1'b0;
      if (raw != db_level[idx]) begin
        next_db_level = raw;
        fwd = 1'b1;
      end
    end else if (!db_pend[idx]) begin
      if (raw != db_level[idx]) begin
        next_db_pend = 1'b1;
        next_db_ts = time_ms;
      end
    end else if (raw == db_level[idx]) begin
      next_db_pend = 1'b0;
    end else if (age(time_ms, db_ts[idx]) >=
                 {49'h0, cfg_db[idx]}) begin
      next_db_level = raw;
      next_db_pend = 1'b0;
      fwd = 1'b1;
      fwd_ts = db_ts[idx];
    end

    // Chatter stage sees only debounced changes
    next_ch_level = ch_level[idx];
    next_ch_blk = ch_blk[idx];
    next_ch_cnt = ch_cnt[idx];
    next_ch_last = ch_last[idx];
    next_ch_blk_ts = ch_blk_ts[idx];
    emit = 1'b0;
    emit_val = ch_level[idx];
    emit_blk = ch_blk[idx];
    emit_ts = time_ms;
    short_gap = age(fwd_ts, ch_last[idx]) <
                {41'h0, chat_ms(cfg_ct[idx])};
    if (cfg_ct[idx] == `EDC_RST_CT) begin
      next_ch_blk = 1'b0;
      next_ch_cnt = `EDC_RST_LIM;
      if (fwd) begin
        next_ch_level = next_db_level;
        emit = 1'b1;
        emit_val = next_db_level;
        emit_blk = 1'b0;
        emit_ts = fwd_ts;
      end
    end else if (ch_blk[idx]) begin
      if (age(time_ms, ch_blk_ts[idx]) >=
          {41'h0, chat_ms(cfg_bt[idx])}) begin
        next_ch_blk = 1'b0;
        next_ch_cnt = `EDC_RST_LIM;
        next_ch_last = time_ms;
        next_ch_level = next_db_level;
        emit = 1'b1;
        emit_val = next_db_level;
        emit_blk = 1'b0;
      end
      // Changes during the block are dropped here
    end else if (fwd) begin
      if (!short_gap) begin
        next_ch_cnt = `EDC_RST_LIM;
        next_ch_last = fwd_ts;
        next_ch_level = next_db_level;
        emit = 1'b1;
        emit_val = next_db_level;
        emit_blk = 1'b0;
        emit_ts = fwd_ts;
      end else if (ch_cnt[idx] >= cfg_lim[idx]) begin
        next_ch_blk = 1'b1;
        next_ch_blk_ts = time_ms;
        next_ch_cnt = `EDC_RST_LIM;
        emit = 1'b1;
        emit_val = ch_level[idx];
        emit_blk = 1'b1;
      end else begin
        next_ch_cnt = ch_cnt[idx] + 8'h01;
        next_ch_last = fwd_ts;
        next_ch_level = next_db_level;
        emit = 1'b1;
        emit_val = next_db_level;
        emit_blk = 1'b0;
        emit_ts = fwd_ts;
      end
    end
  end

  assign wr_ok = emit & buf_ready;
  assign drop = emit & ~buf_ready;
  assign rec_in = {idx, emit_val, emit_ts, emit_blk, ovf_flag};

  // Scanner and per-input filter state
  always @(posedge core_clk) begin
    if (reset) begin
      idx <= {`EDC_IDX_W{1'b0}};
      ovf_flag <= 1'b0;
      for (i = 0; i < `EDC_NUM_INPUTS; i = i + 1) begin
        cfg_inv[i] <= 1'b0;
        cfg_db[i] <= `EDC_RST_DB;
        cfg_ct[i] <= `EDC_RST_CT;
        cfg_lim[i] <= `EDC_RST_LIM;
        cfg_bt[i] <= `EDC_RST_BT;
        db_level[i] <= 1'b0;
        db_pend[i] <= 1'b0;
        db_ts[i] <= {`EDC_TS_W{1'b0}};
        ch_level[i] <= 1'b0;
        ch_blk[i] <= 1'b0;
        ch_cnt[i] <= `EDC_RST_LIM;
        ch_last[i] <= {`EDC_TS_W{1'b0}};
        ch_blk_ts[i] <= {`EDC_TS_W{1'b0}};
      end
    end else begin
      idx <= (idx == LAST_IDX) ? {`EDC_IDX_W{1'b0}} :
             idx + 8'h01;
      // Set wins: a drop in the cycle the flag is sent keeps it set
      if (drop) begin
        ovf_flag <= 1'b1;
      end else if (wr_ok) begin
        ovf_flag <= 1'b0;
      end
      db_level[idx] <= next_db_level;
      db_pend[idx] <= next_db_pend;
      db_ts[idx] <= next_db_ts;
      ch_level[idx] <= next_ch_level;
      ch_blk[idx] <= next_ch_blk;
      ch_cnt[idx] <= next_ch_cnt;
      ch_last[idx] <= next_ch_last;
      ch_blk_ts[idx] <= next_ch_blk_ts;
      if (cfg_write && cfg_index <= LAST_IDX) begin
        cfg_inv[cfg_index] <= cfg_invert;
        cfg_db[cfg_index] <= cfg_debounce_ms;
        cfg_ct[cfg_index] <= cfg_chatter_time;
        cfg_lim[cfg_index] <= cfg_chatter_limit;
        cfg_bt[cfg_index] <= cfg_block_time;
      end
    end
  end

  // Reader removes a record only by its handshake
  edc_event_buffer #(
    .WIDTH(`EDC_REC_W)
  ) u_log (
    .core_clk(core_clk),
    .reset(reset),
    .in_valid(emit),
    .in_ready(buf_ready),
    .in_data(rec_in),
    .out_valid(rec_valid),
    .out_ready(rec_ready),
    .out_data(rec_out)
  );

  assign rec_index = rec_out[`EDC_REC_IDX_HI:`EDC_REC_IDX_LO];
  assign rec_value = rec_out[`EDC_REC_VAL];
  assign rec_time = rec_out[`EDC_REC_TS_HI:`EDC_REC_TS_LO];
  assign rec_blocked = rec_out[`EDC_REC_BLK];
  assign rec_overflow = rec_out[`EDC_REC_OVF];

endmodule

`default_nettype wire

// File: edc_regs.vh
// Constants of the event debounce and chatter filter.
// Included by the filter, its checker and the bench, not by the buffer; definitions only.
`ifndef EDC_REGS_VH
`define EDC_REGS_VH

`define EDC_NUM_INPUTS 200
`define EDC_IDX_W 8
`define EDC_DB_W 15
`define EDC_CT_W 16
`define EDC_LIM_W 8
`define EDC_TS_W 64
`define EDC_CHMS_W 23

`define EDC_CLK_HZ 100000000
`define EDC_TS_UNIT_MS 1
`define EDC_MS_CYCLES (`EDC_CLK_HZ / 1000 * `EDC_TS_UNIT_MS)
`define EDC_TICK_W 17
`define EDC_CHAT_UNIT_MS 23'h000064

`define EDC_RST_DB 15'h0000
`define EDC_RST_CT 16'h0000
`define EDC_RST_LIM 8'h00
`define EDC_RST_BT 16'h0000

`define EDC_REC_W 75
`define EDC_REC_OVF 0
`define EDC_REC_BLK 1
`define EDC_REC_TS_LO 2
`define EDC_REC_TS_HI 65
`define EDC_REC_VAL 66
`define EDC_REC_IDX_LO 67
`define EDC_REC_IDX_HI 74

`endif

// File: edc_event_buffer.v
// Two-entry record buffer with valid and ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

module edc_event_buffer #(
  parameter WIDTH = 75
) (
  input wire core_clk, // System clock
  input wire reset, // Synchronous reset, active high
  input wire in_valid, // Record offered
  output wire in_ready, // Room for a record
  input wire [WIDTH-1:0] in_data, // Offered record
  output wire out_valid, // Record available
  input wire out_ready, // Reader takes record
  output wire [WIDTH-1:0] out_data // Oldest record
);

  reg [WIDTH-1:0] slot [0:1];
  reg wr_ptr;
  reg rd_ptr;
  reg [1:0] count;
  wire push;
  wire pop;

  assign in_ready = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data = slot[rd_ptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always @(posedge core_clk) begin
    if (reset) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      if (push & ~pop) begin
        count <= count + 2'h1;
      end else if (pop & ~push) begin
        count <= count - 2'h1;
      end
    end
  end

  // Storage needs no reset; validity is carried by count
  always @(posedge core_clk) begin
    if (push) begin
      slot[wr_ptr] <= in_data;
    end
  end

endmodule

`default_nettype wire

// File: edc_filter_asserts.sv
// Port-level checks of the event filter chain.
// Assumes a bind to edc_event_filter and one clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "edc_regs.vh"
module edc_filter_asserts #(
  parameter MS_CYCLES = 10
) (
  input wire logic core_clk, // System clock
  input wire logic reset, // Sync reset
  input wire logic rec_valid, // Record available
  input wire logic rec_ready, // Reader takes
  input wire logic [`EDC_IDX_W-1:0] rec_index, // Input number
  input wire logic rec_value, // Filtered level
  input wire logic [`EDC_TS_W-1:0] rec_time, // Stamp
  input wire logic rec_blocked, // Block flag
  input wire logic rec_overflow, // Drop flag
  input wire logic [`EDC_TS_W-1:0] now_ms, // Time base
  input wire logic overflow_pending // Drop not yet reported
);
  integer still;
  logic [`EDC_TS_W-1:0] last_ms;
  // Cycles since the time base last moved
  always @(posedge core_clk) begin
    last_ms <= now_ms;
    if (reset || now_ms != last_ms)
      still <= 0;
    else
      still <= still + 1;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  property p_rst_quiet;
    disable iff (1'b0) reset |=> !rec_valid && now_ms == 64'h0 &&
      !overflow_pending;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("outputs not cleared by reset");
  property p_first_quiet;
    $fell(reset) |-> !rec_valid [*2];
  endproperty
  a_first_quiet: assert property (p_first_quiet)
    else $error("record right after reset");
  property p_ms_step;
    1'b1 |=> now_ms == $past(now_ms) || now_ms == $past(now_ms) + 64'h1;
  endproperty
  a_ms_step: assert property (p_ms_step)
    else $error("time base jumped");
  property p_ms_rate;
    still <= MS_CYCLES;
  endproperty
  a_ms_rate: assert property (p_ms_rate)
    else $error("time base stalled");
  property p_rec_hold;
    rec_valid && !rec_ready |=> rec_valid && $stable(rec_index) &&
      $stable(rec_value) && $stable(rec_time) && $stable(rec_blocked) &&
      $stable(rec_overflow);
  endproperty
  a_rec_hold: assert property (p_rec_hold)
    else $error("record changed before taken");
  property p_stamp_past;
    rec_valid |-> rec_time <= now_ms;
  endproperty
  a_stamp_past: assert property (p_stamp_past)
    else $error("stamp ahead of time base");
  property p_pend_rose;
    $rose(overflow_pending) |-> $past(rec_valid);
  endproperty
  a_pend_rose: assert property (p_pend_rose)
    else $error("drop flagged with room in buffer");
  property p_pend_hold;
    $fell(overflow_pending) |-> rec_valid &&
      (rec_overflow || $past(rec_valid));
  endproperty
  a_pend_hold: assert property (p_pend_hold)
    else $error("drop flag not carried by a record");
endmodule
bind edc_event_filter edc_filter_asserts #(.MS_CYCLES(MS_CYCLES)) u_chk (
  .core_clk(core_clk), .reset(reset), .rec_valid(rec_valid),
  .rec_ready(rec_ready), .rec_index(rec_index), .rec_value(rec_value),
  .rec_time(rec_time), .rec_blocked(rec_blocked),
  .rec_overflow(rec_overflow), .now_ms(now_ms),
  .overflow_pending(overflow_pending));
`default_nettype wire

// File: edc_reader_model.sv
// Application reader taking records from the event log.
// Assumes one clock; stall holds it off to let the log fill.
`timescale 1ns/1ps
`default_nettype none
module edc_reader_model (
  input wire logic core_clk, // System clock
  input wire logic reset, // Sync reset
  input wire logic stall, // Hold off reading
  output logic rec_ready // Take record
);
  // Random gaps mimic a slow application cycle
  always @(posedge core_clk)
    rec_ready <= !reset && !stall && ($urandom % 4 != 0);
endmodule
`default_nettype wire

// File: edc_testbench.sv
// Self-checking bench of the event filter chain.
// Assumes edc_event_filter, edc_reader_model and the checker bind.
`timescale 1ns/1ps
`default_nettype none
`include "edc_regs.vh"
module testbench;
  localparam MS = 10;
  typedef struct {
    logic [7:0] idx;
    logic v;
    logic b;
    logic o;
    logic [63:0] lo;
  } edc_exp_t;
  edc_exp_t expq[$];
  edc_exp_t e;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [`EDC_NUM_INPUTS-1:0] binary_input_value = 200'h0;
  logic cfg_write = 1'b0;
  logic [7:0] cfg_index = 8'h00;
  logic cfg_invert = 1'b0;
  logic [14:0] cfg_debounce_ms = 15'h0000;
  logic [15:0] cfg_chatter_time = 16'h0000;
  logic [7:0] cfg_chatter_limit = 8'h00;
  logic [15:0] cfg_block_time = 16'h0000;
  logic stall = 1'b0;
  logic [63:0] cyc = 64'h0;
  logic [63:0] lo3;
  wire rec_valid, rec_ready, rec_value, rec_blocked, rec_overflow;
  wire overflow_pending;
  wire [7:0] rec_index;
  wire [63:0] rec_time;
  integer mismatches = 0;
  integer checked = 0;
  integer r;
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk)
    if (!reset)
      cyc <= cyc + 64'h1;
  edc_event_filter #(.MS_CYCLES(MS)) uut (
    .core_clk(core_clk), .reset(reset),
    .binary_input_value(binary_input_value), .cfg_write(cfg_write),
    .cfg_index(cfg_index), .cfg_invert(cfg_invert),
    .cfg_debounce_ms(cfg_debounce_ms), .cfg_chatter_time(cfg_chatter_time),
    .cfg_chatter_limit(cfg_chatter_limit), .cfg_block_time(cfg_block_time),
    .rec_valid(rec_valid), .rec_ready(rec_ready), .rec_index(rec_index),
    .rec_value(rec_value), .rec_time(rec_time), .rec_blocked(rec_blocked),
    .rec_overflow(rec_overflow), .now_ms(), 
    .overflow_pending(overflow_pending));
  edc_reader_model u_reader (.core_clk(core_clk), .reset(reset),
    .stall(stall), .rec_ready(rec_ready));
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Expected record; stamp must lie close after the change time lo
  task automatic note(input int i, input logic v, input logic b,
      input logic o, input logic [63:0] lo);
    expq.push_back('{i[7:0], v, b, o, lo});
  endtask
  task automatic set_in(input int i, input logic v);
    @(posedge core_clk);
    binary_input_value[i] <= v;
  endtask
  task automatic cfg(input int i, input logic inv, input logic [14:0] db,
      input logic [15:0] ct, input logic [7:0] lim, input logic [15:0] bt);
    @(posedge core_clk);
    cfg_write <= 1'b1;
    cfg_index <= i[7:0];
    cfg_invert <= inv;
    cfg_debounce_ms <= db;
    cfg_chatter_time <= ct;
    cfg_chatter_limit <= lim;
    cfg_block_time <= bt;
    @(posedge core_clk);
    cfg_write <= 1'b0;
  endtask
  task automatic drain;
    for (int k = 0; k < 4000 && expq.size() != 0; k++)
      @(posedge core_clk);
  endtask
  task automatic test_done;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge core_clk)
    if (!reset && rec_valid === 1'b1 && rec_ready === 1'b1) begin
      checked = checked + 1;
      if (expq.size() == 0) begin
        mismatches = mismatches + 1;
        $display("[FAIL] rec_index expected none seen %0d", rec_index);
      end else begin
        e = expq.pop_front();
        if ({rec_index, rec_value, rec_blocked, rec_overflow} !==
            {e.idx, e.v, e.b, e.o}) begin
          mismatches = mismatches + 1;
          $display("[FAIL] record expected %h seen %h",
            {e.idx, e.v, e.b, e.o},
            {rec_index, rec_value, rec_blocked, rec_overflow});
        end
        if (rec_time + 64'h1 < e.lo || rec_time > e.lo + 64'h2D) begin
          mismatches = mismatches + 1;
          $display("[FAIL] rec_time expected near %0d seen %0d", e.lo,
            rec_time);
        end
      end
    end
  initial begin
    repeat (60000) @(posedge core_clk);
    mismatches = mismatches + 1;
    $display("[FAIL] watchdog expected done seen timeout");
    test_done();
  end
  initial begin
    void'($urandom(32'h50d9));
    tick(8);
    reset <= 1'b0;
    tick(20);
    // Zero debounce after reset forwards at once
    r = 40 + ($urandom % 100);
    set_in(r, 1'b1);
    note(r, 1'b1, 1'b0, 1'b0, cyc / MS);
    tick(400);
    // Inversion alone already flips the filtered level
    note(5, 1'b1, 1'b0, 1'b0, cyc / MS);
    cfg(5, 1'b1, 15'h0000, 16'h0000, 8'h00, 16'h0000);
    tick(400);
    set_in(5, 1'b1);
    note(5, 1'b0, 1'b0, 1'b0, cyc / MS);
    tick(400);
    // Debounce 50 ms: a short glitch vanishes, a held change keeps its stamp
    cfg(7, 1'b0, 15'h0032, 16'h0000, 8'h00, 16'h0000);
    set_in(7, 1'b1);
    tick(200);
    set_in(7, 1'b0);
    tick(1000);
    set_in(7, 1'b1);
    note(7, 1'b1, 1'b0, 1'b0, cyc / MS);
    tick(1000);
    // Chatter: 100 ms window, limit 1, block 100 ms
    cfg(9, 1'b0, 15'h0000, 16'h0001, 8'h01, 16'h0001);
    tick(1500);
    set_in(9, 1'b1);
    note(9, 1'b1, 1'b0, 1'b0, cyc / MS);
    tick(300);
    set_in(9, 1'b0);
    note(9, 1'b0, 1'b0, 1'b0, cyc / MS);
    tick(300);
    set_in(9, 1'b1);
    lo3 = cyc / MS;
    note(9, 1'b0, 1'b1, 1'b0, lo3);
    tick(300);
    set_in(9, 1'b0);
    note(9, 1'b0, 1'b0, 1'b0, lo3 + 64'h64);
    tick(1800);
    drain();
    // Full log: third event dropped, next record flagged
    stall <= 1'b1;
    for (int i = 20; i < 23; i++) begin
      set_in(i, 1'b1);
      if (i < 22)
        note(i, 1'b1, 1'b0, 1'b0, cyc / MS);
      tick(300);
    end
    checked = checked + 1;
    if (overflow_pending !== 1'b1) begin
      mismatches = mismatches + 1;
      $display("[FAIL] overflow_pending expected 1 seen %b",
        overflow_pending);
    end
    stall <= 1'b0;
    drain();
    set_in(23, 1'b1);
    note(23, 1'b1, 1'b0, 1'b1, cyc / MS);
    tick(400);
    drain();
    if (expq.size() != 0) begin
      mismatches = mismatches + 1;
      $display("[FAIL] records expected 0 left seen %0d", expq.size());
    end
    test_done();
  end
endmodule
`default_nettype wire
